// ===== verilog/afeprs_pkg.sv
package afeprs_pkg;

  // ****************************************
  // Bus and register index map
  // ****************************************
  localparam int AFEPRS_DW = 32;
  localparam int AFEPRS_AW = 12;
  localparam logic [9:0] IDX_FULL_RESET_KEY = 10'h000;
  localparam logic [9:0] IDX_SERIAL_PORT_RESET_CTRL = 10'h002;
  localparam logic [9:0] IDX_POWER_MODE_CTRL_STATUS = 10'h008;
  localparam logic [9:0] IDX_CONVERSION_RESTART = 10'h00b;
  localparam logic [9:0] IDX_CONVERTER_AUX_CTRL = 10'h012;
  localparam logic [9:0] IDX_DATA_AVAILABLE_STATUS = 10'h018;
  localparam logic [9:0] IDX_RESULT_HIGH_BYTE = 10'h01a;
  localparam logic [9:0] IDX_RESULT_LOW_BYTE = 10'h01b;
  localparam logic [9:0] IDX_CHANNEL_STATUS = 10'h01e;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h020;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h021;

  // ****************************************
  // Field values and positions
  // ****************************************
  localparam logic [7:0] FULL_RESET_KEY_VALUE = 8'hc3;
  localparam logic [7:0] DATA_NOT_AVAILABLE = 8'hff;
  localparam logic [7:0] DATA_AVAILABLE = 8'h00;
  localparam int SPR_EN_BIT = 0;
  localparam int RESTART_BIT = 0;
  localparam int AUX_CAL_RESET_BIT = 6;
  localparam int AUX_DET_BYPASS_BIT = 5;
  localparam int AUX_CLK_SEL_BIT = 4;
  localparam int AUX_CUR_LSB = 0;
  localparam int AUX_CUR_W = 4;
  localparam logic [6:0] AUX_WRITABLE_MASK = 7'h7f;
  localparam logic [6:0] AUX_RESET = 7'h00;
  localparam int STS_STALE_BIT = 0;
  localparam int STS_SCAN_PENDING_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int IRQ_NEW_RESULT_BIT = 0;
  localparam int IRQ_STALE_READ_BIT = 1;
  localparam logic [AFEPRS_DW-1:0] RDATA_ZERO = 32'h0000_0000;

  // Host must space result reads by at least this much
  localparam int RESULT_READ_SPACING_US = 72;
  localparam int CLK_MHZ = 100;
  localparam int RESULT_READ_SPACING_CYC = RESULT_READ_SPACING_US * CLK_MHZ;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_DOWN = 2'h1,
    PWR_UNDEF = 2'h2,
    PWR_STANDBY = 2'h3
  } afeprs_pwr_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } afeprs_bus_t;

endpackage

// ===== verilog/afeprs_regs.sv
`timescale 1ns/100ps

module afeprs_regs
  import afeprs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [afeprs_pkg::AFEPRS_AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [afeprs_pkg::AFEPRS_DW-1:0] hwdata,
  input wire logic hready,
  output logic [afeprs_pkg::AFEPRS_DW-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  input wire logic scan_update_pending,
  output logic [1:0] power_mode,
  output logic serial_port_reset_en,
  output logic ext_clock_detect_bypass,
  output logic clock_select_external,
  output logic [3:0] excitation_current_select,
  output logic conversion_restart_pulse,
  output logic full_reset_pulse,
  output logic cal_coeff_clear_pulse,
  output logic irq
);
  import afeprs_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    // Bus tracking
    afeprs_bus_t bus;
    logic [9:0] idx;
    logic wr;
    logic ready;
    logic [AFEPRS_DW-1:0] rdata;
    // Control registers
    logic spr_en;
    logic spr_locked;
    afeprs_pwr_t pwr;
    logic [6:0] aux;
    logic clk_ext;
    // Result and status
    logic fresh;
    logic [15:0] result;
    logic stale;
    logic scan_pend;
    // Pulses and interrupts
    logic restart;
    logic full_rst;
    logic cal_clr;
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
  } afeprs_state_t;

  afeprs_state_t state_reg;
  afeprs_state_t state_next;

  // ****************************************
  // Reset value
  // ****************************************
  localparam afeprs_state_t STATE_RESET = '{
    bus: BUS_IDLE,
    idx: '0,
    wr: 1'b0,
    ready: 1'b1,
    rdata: RDATA_ZERO,
    spr_en: 1'b0,
    spr_locked: 1'b0,
    pwr: PWR_ACTIVE,
    aux: AUX_RESET,
    clk_ext: 1'b0,
    fresh: 1'b0,
    result: '0,
    stale: 1'b0,
    scan_pend: 1'b0,
    restart: 1'b0,
    full_rst: 1'b0,
    cal_clr: 1'b0,
    irq_sts: '0,
    irq_mask: '0,
    irq: 1'b0
  };

  // ****************************************
  // Helper functions
  // ****************************************
  // Address phase accepted by this slave
  function automatic logic bus_request(input logic sel, input logic [1:0] trans, input logic rdy);
    return sel && trans[1] && rdy;
  endfunction

  // Only the exact key value starts a full reset
  function automatic logic key_matches(input logic [7:0] b);
    return b == FULL_RESET_KEY_VALUE;
  endfunction

  // Every power code but the undefined one is taken
  function automatic logic power_code_legal(input logic [1:0] c);
    return c != PWR_UNDEF;
  endfunction

  // Pending sticky events whose mask bit is set
  function automatic logic irq_level(input logic [IRQ_W-1:0] sts, input logic [IRQ_W-1:0] msk);
    return |(sts & msk);
  endfunction

  // Clock select counts only while detection is bypassed
  function automatic logic ext_clock_chosen(input logic [6:0] a);
    return a[AUX_DET_BYPASS_BIT] & a[AUX_CLK_SEL_BIT];
  endfunction

  // Register read decode, used for the read data path
  function automatic logic [AFEPRS_DW-1:0] read_word(input afeprs_state_t s, input logic [9:0] idx);
    logic [AFEPRS_DW-1:0] w;
    w = RDATA_ZERO;
    // Unlisted indices and reserved bits read zero
    case (idx)
      IDX_SERIAL_PORT_RESET_CTRL: w[SPR_EN_BIT] = s.spr_en;
      IDX_POWER_MODE_CTRL_STATUS: w[1:0] = s.pwr;
      IDX_CONVERTER_AUX_CTRL: w[6:0] = s.aux;
      IDX_DATA_AVAILABLE_STATUS: w[7:0] = s.fresh ? DATA_AVAILABLE : DATA_NOT_AVAILABLE;
      // Result bytes, high then low
      IDX_RESULT_HIGH_BYTE: w[7:0] = s.result[15:8];
      IDX_RESULT_LOW_BYTE: w[7:0] = s.result[7:0];
      // Status flags: stale from host high-byte reads, scan pending from the converter side
      IDX_CHANNEL_STATUS:
      begin
        w[STS_STALE_BIT] = s.stale;
        w[STS_SCAN_PENDING_BIT] = s.scan_pend;
      end
      // Own interrupt registers
      IDX_IRQ_STATUS: w[IRQ_W-1:0] = s.irq_sts;
      IDX_IRQ_MASK: w[IRQ_W-1:0] = s.irq_mask;
      default: w = RDATA_ZERO;
    endcase
    return w;
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    // Scratch values for this cycle
    logic take;
    logic do_wr;
    logic do_rd;
    logic [7:0] wb;
    logic [IRQ_W-1:0] ev;
    take = 1'b0;
    do_wr = 1'b0;
    do_rd = 1'b0;
    wb = hwdata[7:0];
    ev = '0;
    state_next = state_reg;
    // Pulses drop unless set again below
    state_next.restart = 1'b0;
    state_next.full_rst = 1'b0;
    state_next.cal_clr = 1'b0;

    // Bus phase tracking, one wait state per transfer
    take = bus_request(hsel, htrans, hready);
    case (state_reg.bus)
      // No transfer in flight, slave ready
      BUS_IDLE:
      begin
        state_next.ready = 1'b1;
      end

      // Wait cycle over: apply the write or load read data
      BUS_DATA:
      begin
        do_wr = state_reg.wr;
        do_rd = !state_reg.wr;
        state_next.ready = 1'b1;
        state_next.bus = BUS_IDLE;
        if (do_rd)
        begin
          state_next.rdata = read_word(state_reg, state_reg.idx);
        end
      end

      // Unused encoding falls back to idle
      default:
      begin
        state_next.bus = BUS_IDLE;
        state_next.ready = 1'b1;
      end
    endcase

    // Accepted address phase opens the data phase
    if (take)
    begin
      state_next.bus = BUS_DATA;
      state_next.idx = haddr[AFEPRS_AW-1:2];
      state_next.wr = hwrite;
      state_next.ready = 1'b0;
    end

    // Converter side: new result and scan status
    // Pending flag shows in the status one cycle late
    state_next.scan_pend = scan_update_pending;

    // A new result arms the data-available code
    if (result_valid)
    begin
      state_next.result = result_data;
      state_next.fresh = 1'b1;
      ev[IRQ_NEW_RESULT_BIT] = 1'b1;
    end

    // Read side effects on the result bytes
    // High byte read judges fresh against stale
    if (do_rd && state_reg.idx == IDX_RESULT_HIGH_BYTE)
    begin
      state_next.stale = !state_reg.fresh;
      ev[IRQ_STALE_READ_BIT] = !state_reg.fresh;
    end

    // Low byte read consumes it; a result landing now wins
    if (do_rd && state_reg.idx == IDX_RESULT_LOW_BYTE && !result_valid)
    begin
      state_next.fresh = 1'b0;
    end

    // Register writes
    if (do_wr)
    begin
      case (state_reg.idx)
        // Key register: only the exact key acts
        IDX_FULL_RESET_KEY:
        begin
          if (key_matches(wb))
          begin
            // Pulses for the conversion and coefficients
            state_next.full_rst = 1'b1;
            state_next.restart = 1'b1;
            state_next.cal_clr = state_reg.aux[AUX_CAL_RESET_BIT];
            // Control registers and result flags back to their reset values; interrupt mask and status keep theirs
            state_next.spr_en = 1'b0;
            state_next.spr_locked = 1'b0;
            state_next.pwr = PWR_ACTIVE;
            state_next.aux = AUX_RESET;
            state_next.fresh = 1'b0;
            state_next.stale = 1'b0;
          end
        end

        // Serial-port reset: first write sticks until key
        IDX_SERIAL_PORT_RESET_CTRL:
        begin
          if (!state_reg.spr_locked)
          begin
            state_next.spr_en = wb[SPR_EN_BIT];
            state_next.spr_locked = 1'b1;
          end
        end

        // Power request takes effect at once
        IDX_POWER_MODE_CTRL_STATUS:
        begin
          if (power_code_legal(wb[1:0]))
          begin
            state_next.pwr = afeprs_pwr_t'(wb[1:0]);
          end
        end

        // Restart is a pulse; a zero write does nothing
        IDX_CONVERSION_RESTART:
        begin
          state_next.restart = wb[RESTART_BIT];
        end

        // Auxiliary settings, bit seven reads zero
        IDX_CONVERTER_AUX_CTRL:
        begin
          state_next.aux = wb[6:0] & AUX_WRITABLE_MASK;
        end

        // Write one to clear a sticky event
        IDX_IRQ_STATUS:
        begin
          state_next.irq_sts = state_reg.irq_sts & ~hwdata[IRQ_W-1:0];
        end

        // Interrupt mask, same layout as status
        IDX_IRQ_MASK:
        begin
          state_next.irq_mask = hwdata[IRQ_W-1:0];
        end

        // Read-only and unmapped indices ignore writes
        default:
        begin
          state_next.irq_mask = state_reg.irq_mask;
        end
      endcase
    end

    // Sticky events win over a clear in the same cycle
    state_next.irq_sts = state_next.irq_sts | ev;
    state_next.irq = irq_level(state_next.irq_sts, state_next.irq_mask);

    // Registered clock choice keeps the pin on a flip-flop
    state_next.clk_ext = ext_clock_chosen(state_next.aux);
  end

  // ****************************************
  // State register
  // ****************************************
  // Asynchronous reset, then next state on every edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs from flip-flops, hresp tied low
  // ****************************************
  // Bus response
  assign hrdata = state_reg.rdata;
  assign hreadyout = state_reg.ready;
  assign hresp = 1'b0; // Always OKAY

  // Mode and clock settings
  assign power_mode = state_reg.pwr;
  assign serial_port_reset_en = state_reg.spr_en;
  assign ext_clock_detect_bypass = state_reg.aux[AUX_DET_BYPASS_BIT];
  assign clock_select_external = state_reg.clk_ext;
  assign excitation_current_select = state_reg.aux[AUX_CUR_LSB +: AUX_CUR_W];

  // Single-cycle pulses
  assign conversion_restart_pulse = state_reg.restart;
  assign full_reset_pulse = state_reg.full_rst;
  assign cal_coeff_clear_pulse = state_reg.cal_clr;

  // Interrupt level
  assign irq = state_reg.irq;

endmodule

// ===== verification/afeprs_sva.sv
`timescale 1ns/100ps
module afeprs_sva
  import afeprs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [afeprs_pkg::AFEPRS_AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [afeprs_pkg::AFEPRS_DW-1:0] hwdata,
  input wire logic hready,
  input wire logic [afeprs_pkg::AFEPRS_DW-1:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  input wire logic scan_update_pending,
  input wire logic [1:0] power_mode,
  input wire logic serial_port_reset_en,
  input wire logic ext_clock_detect_bypass,
  input wire logic clock_select_external,
  input wire logic [3:0] excitation_current_select,
  input wire logic conversion_restart_pulse,
  input wire logic full_reset_pulse,
  input wire logic cal_coeff_clear_pulse,
  input wire logic irq
);
  // ****************************************
  // Transfer tracking
  // ****************************************
  logic a_v;
  logic a_w;
  logic [9:0] a_i;
  logic ap;
  logic keyw;
  // Transfer pending between address phase and completion
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      a_v <= 1'b0;
    else if (hsel && htrans[1] && hready)
      a_v <= 1'b1;
    else if (hreadyout)
      a_v <= 1'b0;
  end
  // Kind and index of the pending transfer
  always_ff @(posedge hclk)
  begin
    if (hsel && htrans[1] && hready)
    begin
      a_w <= hwrite;
      a_i <= haddr[AFEPRS_AW-1:2];
    end
  end
  // Write applied at the end of the wait cycle
  assign ap = a_v && !hreadyout && a_w;
  assign keyw = ap && a_i == IDX_FULL_RESET_KEY && hwdata[7:0] == FULL_RESET_KEY_VALUE;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_key_pulse: assert property (full_reset_pulse == $past(keyw))
    else $error("full reset pulse mismatch");
  chk_restart_pulse: assert property (conversion_restart_pulse ==
    $past(keyw || ap && a_i == IDX_CONVERSION_RESTART && hwdata[RESTART_BIT])) else $error("restart pulse mismatch");
  chk_cal_clear: assert property (cal_coeff_clear_pulse |-> full_reset_pulse)
    else $error("coefficient clear without full reset");
  chk_clock_select: assert property (clock_select_external |-> ext_clock_detect_bypass)
    else $error("external clock without bypass");
  chk_wait_state: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("wait state length wrong");
  chk_power_code: assert property (power_mode != PWR_UNDEF)
    else $error("undefined power mode");
  chk_power_hold: assert property ($changed(power_mode) |->
    $past(keyw || ap && a_i == IDX_POWER_MODE_CTRL_STATUS)) else $error("power mode changed unasked");
  chk_lock_change: assert property ($changed(serial_port_reset_en) |->
    $past(keyw || ap && a_i == IDX_SERIAL_PORT_RESET_CTRL)) else $error("serial reset enable changed unasked");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  cover property (full_reset_pulse);
  cover property (cal_coeff_clear_pulse);
  cover property ($rose(irq));
endmodule

bind afeprs_regs afeprs_sva afeprs_sva_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .result_valid(result_valid), .result_data(result_data),
  .scan_update_pending(scan_update_pending), .power_mode(power_mode), .serial_port_reset_en(serial_port_reset_en),
  .ext_clock_detect_bypass(ext_clock_detect_bypass), .clock_select_external(clock_select_external),
  .excitation_current_select(excitation_current_select), .conversion_restart_pulse(conversion_restart_pulse),
  .full_reset_pulse(full_reset_pulse), .cal_coeff_clear_pulse(cal_coeff_clear_pulse), .irq(irq));

// ===== verification/afeprs_conv.sv
`timescale 1ns/100ps
// ****************************************
// Converter side result source
// ****************************************
module afeprs_conv
(
  input wire logic hclk,
  input wire logic fire,
  input wire logic [15:0] value,
  output logic result_valid,
  output logic [15:0] result_data
);
  // Idle with no result at start
  initial
  begin
    result_valid = 1'b0;
    result_data = 16'h0000;
  end
  // One-cycle result; data keeps toggling while not valid
  always @(posedge hclk)
  begin
    result_valid <= fire;
    result_data <= fire ? value : ~result_data;
  end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/100ps
module testbench
  import afeprs_pkg::*;
;
  // ****************************************
  // Host side stimulus
  // ****************************************
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0, scan_update_pending = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic [15:0] rv = 16'h0000, result_data;
  logic hreadyout, hresp, result_valid, serial_port_reset_en, ext_clock_detect_bypass, clock_select_external;
  logic conversion_restart_pulse, full_reset_pulse, cal_coeff_clear_pulse, irq;
  logic [1:0] power_mode;
  logic [3:0] excitation_current_select;
  logic [7:0] n_fr = 8'h00, n_cc = 8'h00, n_rs = 8'h00;
  logic [1:0] pc [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  logic [1:0] pe [4] = '{2'h1, 2'h3, 2'h3, 2'h0};
  int n_errors = 0, n_tests = 0;
  wire logic [31:0] outs = {23'h0, power_mode, serial_port_reset_en, ext_clock_detect_bypass,
    clock_select_external, excitation_current_select};
  wire logic [31:0] cnts = {8'h00, n_fr, n_cc, n_rs};
  afeprs_regs afeprs_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .result_valid(result_valid), .result_data(result_data),
    .scan_update_pending(scan_update_pending), .power_mode(power_mode), .serial_port_reset_en(serial_port_reset_en),
    .ext_clock_detect_bypass(ext_clock_detect_bypass), .clock_select_external(clock_select_external),
    .excitation_current_select(excitation_current_select), .conversion_restart_pulse(conversion_restart_pulse),
    .full_reset_pulse(full_reset_pulse), .cal_coeff_clear_pulse(cal_coeff_clear_pulse), .irq(irq));
  afeprs_conv afeprs_conv_i (.hclk(hclk), .fire(fire), .value(rv), .result_valid(result_valid),
    .result_data(result_data));
  always #5 hclk = ~hclk;
  // Count the one-cycle pulses
  always @(posedge hclk)
  begin
    n_fr <= n_fr + {7'h00, full_reset_pulse};
    n_cc <= n_cc + {7'h00, cal_coeff_clear_pulse};
    n_rs <= n_rs + {7'h00, conversion_restart_pulse};
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Single word transfer, held until hready is sampled high
  task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d, output logic [31:0] r);
    haddr <= {i, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, i, d, r);
  endtask
  task automatic rd(input logic [9:0] i, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, i, 32'h0, r);
    chk(r, e);
  endtask
  task automatic pulse_result(input logic [15:0] v);
    rv <= v;
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog against a hung transfer
  initial
  begin
    repeat (40000) @(posedge hclk);
    n_errors++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(IDX_SERIAL_PORT_RESET_CTRL, 32'h0);
    rd(IDX_POWER_MODE_CTRL_STATUS, 32'h0);
    rd(IDX_CONVERTER_AUX_CTRL, 32'h0);
    rd(IDX_DATA_AVAILABLE_STATUS, 32'hff);
    rd(IDX_CHANNEL_STATUS, 32'h0);
    rd(IDX_IRQ_MASK, 32'h0);
    chk(outs, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      wr(IDX_POWER_MODE_CTRL_STATUS, {30'h0, pc[k]});
      rd(IDX_POWER_MODE_CTRL_STATUS, {30'h0, pe[k]});
      chk(outs, {23'h0, pe[k], 7'h00});
    end
    wr(IDX_CONVERTER_AUX_CTRL, 32'h1a);
    chk(outs, 32'h00a);
    wr(IDX_CONVERTER_AUX_CTRL, 32'hff);
    rd(IDX_CONVERTER_AUX_CTRL, 32'h7f);
    chk(outs, 32'h03f);
    wr(IDX_SERIAL_PORT_RESET_CTRL, 32'h1);
    wr(IDX_SERIAL_PORT_RESET_CTRL, 32'h0);
    rd(IDX_SERIAL_PORT_RESET_CTRL, 32'h1);
    wr(IDX_FULL_RESET_KEY, 32'h55);
    rd(IDX_SERIAL_PORT_RESET_CTRL, 32'h1);
    chk(cnts, 32'h0);
    wr(IDX_FULL_RESET_KEY, 32'hc3);
    rd(IDX_CONVERTER_AUX_CTRL, 32'h0);
    chk(cnts, 32'h010101);
    chk(outs, 32'h0);
    wr(IDX_SERIAL_PORT_RESET_CTRL, 32'h1);
    rd(IDX_SERIAL_PORT_RESET_CTRL, 32'h1);
    wr(IDX_FULL_RESET_KEY, 32'hc3);
    wr(IDX_CONVERSION_RESTART, 32'h0);
    wr(IDX_CONVERSION_RESTART, 32'h1);
    rd(IDX_IRQ_STATUS, 32'h0);
    chk(cnts, 32'h020103);
    wr(IDX_IRQ_MASK, 32'h1);
    pulse_result(16'h8001);
    chk({31'h0, irq}, 32'h1);
    rd(IDX_DATA_AVAILABLE_STATUS, 32'h0);
    rd(IDX_RESULT_HIGH_BYTE, 32'h80);
    rd(IDX_CHANNEL_STATUS, 32'h0);
    rd(IDX_RESULT_LOW_BYTE, 32'h01);
    rd(IDX_DATA_AVAILABLE_STATUS, 32'hff);
    repeat (RESULT_READ_SPACING_CYC) @(posedge hclk);
    rd(IDX_RESULT_HIGH_BYTE, 32'h80);
    rd(IDX_CHANNEL_STATUS, 32'h1);
    rd(IDX_IRQ_STATUS, 32'h3);
    wr(IDX_IRQ_STATUS, 32'h3);
    rd(IDX_IRQ_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 32'h0);
    pulse_result(16'h1234);
    chk({31'h0, irq}, 32'h0);
    rd(IDX_IRQ_STATUS, 32'h1);
    scan_update_pending <= 1'b1;
    rd(IDX_CHANNEL_STATUS, 32'h3);
    scan_update_pending <= 1'b0;
    rd(IDX_CHANNEL_STATUS, 32'h1);
    wr(10'h004, 32'h0);
    rd(10'h004, 32'h0);
    rd(10'h3ff, 32'h0);
    tally_and_finish();
  end
endmodule
